// ===== ssm_pkg.sv
// Behaviour
// - Sole bus master, serial clock selectable between 100 kHz and 400 kHz.
// - Power-on configuration load from an EEPROM always runs at 400 kHz.
// - Only this master starts, clocks and stops a transaction.
// - Start is SDA falling with SCL high; stop is SDA rising with SCL high.
// - The transmitter changes SDA only while SCL is low.
// - Every byte travels most significant bit first.
// - First byte of each phase is 7-bit address plus direction bit, 1 read.
// - The receiver acknowledges each byte by holding SDA low on the ninth pulse.
// - On the final received byte the master leaves SDA released, no acknowledge.
// - Write sends start, address with write bit, sub-address, data, checking acks.
// - After the last data byte is acknowledged the master sends a stop.
// - A write carries at most eight data bytes to consecutive registers.
// - A read is a dummy write phase followed by a separate read phase.
// - Each read returns exactly one byte; no sequential reads.
// - The dummy write carries the sub-address byte and no data byte.
// - Read phase sends repeated start, address with read bit, then takes eight bits.
// - A rate control bit selects 400 kHz when set; when clear, 100 kHz except for an EEPROM load.
// - A direction control bit selects read when set and write when clear.
// - A ready flag is 1 when idle and 0 when busy; an error flag exists.
// - A 3-bit field sets the byte count; a 7-bit field holds the target address.
package ssm_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int SYS_CLOCK_PERIOD_NS = 5;
  localparam int SCL_SLOW_PERIOD_NS = 10000;
  localparam int SCL_FAST_PERIOD_NS = 2500;
  // Each serial clock period is split in four quarters; a quarter is a least time.
  localparam int SLOW_QUARTER_CYCLES =
    (SCL_SLOW_PERIOD_NS + 4 * SYS_CLOCK_PERIOD_NS - 1) / (4 * SYS_CLOCK_PERIOD_NS);
  localparam int FAST_QUARTER_CYCLES =
    (SCL_FAST_PERIOD_NS + 4 * SYS_CLOCK_PERIOD_NS - 1) / (4 * SYS_CLOCK_PERIOD_NS);
  localparam logic [9:0] SLOW_QUARTER_LIMIT = 10'(SLOW_QUARTER_CYCLES - 1);
  localparam logic [9:0] FAST_QUARTER_LIMIT = 10'(FAST_QUARTER_CYCLES - 1);

  // ----------------------------------------------------------------------
  // Protocol constants
  // ----------------------------------------------------------------------
  localparam logic RW_READ = 1'b1;
  localparam logic RW_WRITE = 1'b0;
  localparam logic [3:0] ACK_BIT_INDEX = 4'h8;
  localparam logic [3:0] MAX_WRITE_BYTES = 4'h8;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_BIT = 2'b10,
    ST_STOP = 2'b11
  } ssm_state_t;

  typedef enum logic [2:0] {
    STG_ADDR_WR = 3'b000,
    STG_SUB = 3'b001,
    STG_DATA = 3'b010,
    STG_ADDR_RD = 3'b011,
    STG_READ = 3'b100
  } ssm_stage_t;

  typedef struct packed {
    logic readMode;
    logic highSpeed;
    logic eepromLoad;
    logic [2:0] byteCount;
    logic [6:0] targetAddress;
    logic [7:0] subAddress;
    logic [63:0] writeData;
  } ssm_request_t;

  typedef struct packed {
    logic ready;
    logic error;
    logic [7:0] readData;
  } ssm_status_t;

  typedef struct packed {
    ssm_state_t state;
    ssm_stage_t stage;
    logic [1:0] quarter;
    logic [3:0] bitIdx;
    logic [2:0] dataIdx;
    logic [3:0] total;
    logic [7:0] shift;
    logic fast;
    logic sclLow;
    logic sdaLow;
    logic [1:0] sdaSync;
    ssm_request_t req;
    ssm_status_t status;
  } ssm_core_t;

  typedef struct packed {
    logic [9:0] count;
  } ssm_div_t;

  localparam ssm_core_t CORE_RESET = '{
    state: ST_IDLE,
    stage: STG_ADDR_WR,
    quarter: 2'h0,
    bitIdx: 4'h0,
    dataIdx: 3'h0,
    total: 4'h0,
    shift: 8'h00,
    fast: 1'b0,
    sclLow: 1'b0,
    sdaLow: 1'b0,
    sdaSync: 2'h3,
    req: '0,
    status: '{ready: 1'b1, error: 1'b0, readData: 8'h00}
  };

  // A count field of zero stands for the full eight bytes.
  function automatic logic [3:0] byteTotal(input logic [2:0] n);
    byteTotal = (n == 3'h0) ? MAX_WRITE_BYTES : {1'b0, n};
  endfunction : byteTotal

  function automatic logic [7:0] byteOf(input logic [63:0] data, input logic [2:0] idx);
    byteOf = data[{idx, 3'h0} +: 8];
  endfunction : byteOf

endpackage : ssm_pkg

// ===== ssm_rate_divider.sv
`timescale 1ns/1ps
module ssm_rate_divider (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic run,
  input wire logic fast,
  output logic tick
);

  ssm_pkg::ssm_div_t div_q;
  ssm_pkg::ssm_div_t div_d;
  logic [9:0] limit;

  // ----------------------------------------------------------------------
  // Quarter-period enable
  // ----------------------------------------------------------------------
  assign limit = fast ? ssm_pkg::FAST_QUARTER_LIMIT : ssm_pkg::SLOW_QUARTER_LIMIT;
  assign tick = run && (div_q.count == limit);

  always_comb begin
    div_d = div_q;
    if (!run || tick) begin
      div_d.count = 10'h000;
    end else begin
      div_d.count = div_q.count + 10'h001;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= '0;
    end else begin
      div_q <= div_d;
    end
  end

  quarter_spacing_a: assert property (@(posedge clock) disable iff (!rst_n)
    (tick && run) |=> !tick [*8])
    else $error("Quarter enable pulses too close together.");

endmodule : ssm_rate_divider

// ===== ssm_master.sv
`timescale 1ns/1ps
module ssm_master (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic startPulse,
  input wire ssm_pkg::ssm_request_t request,
  output ssm_pkg::ssm_status_t status,
  output logic sclOut,
  output logic sclOe,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe
);

  ssm_pkg::ssm_core_t core_q;
  ssm_pkg::ssm_core_t core_d;
  logic tick;
  logic running;

  // ----------------------------------------------------------------------
  // Bit timing
  // ----------------------------------------------------------------------
  assign running = (core_q.state != ssm_pkg::ST_IDLE);

  ssm_rate_divider u_divider (
    .clock(clock),
    .rst_n(rst_n),
    .run(running),
    .fast(core_q.fast),
    .tick(tick)
  );

  // ----------------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------------
  // Both lines are open drain: the enable pulls low, release lets the pull-up win.
  assign sclOut = 1'b0;
  assign sclOe = core_q.sclLow;
  assign sdaOut = 1'b0;
  assign sdaOe = core_q.sdaLow;
  assign status = core_q.status;

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_comb begin
    core_d = core_q;
    core_d.sdaSync = {core_q.sdaSync[0], sdaIn};
    unique case (core_q.state)
      ssm_pkg::ST_IDLE: begin
        // A launch while busy is ignored; software must wait for ready.
        if (startPulse && core_q.status.ready) begin
          core_d.req = request;
          core_d.status.ready = 1'b0;
          core_d.status.error = 1'b0;
          core_d.fast = request.highSpeed || request.eepromLoad;
          core_d.total = ssm_pkg::byteTotal(request.byteCount);
          core_d.stage = ssm_pkg::STG_ADDR_WR;
          core_d.shift = {request.targetAddress, ssm_pkg::RW_WRITE};
          core_d.dataIdx = 3'h0;
          core_d.quarter = 2'h0;
          core_d.state = ssm_pkg::ST_START;
        end
      end
      ssm_pkg::ST_START: begin
        if (tick) begin
          core_d.quarter = core_q.quarter + 2'h1;
          unique case (core_q.quarter)
            2'h0: core_d.sdaLow = 1'b0;
            2'h1: core_d.sclLow = 1'b0;
            2'h2: core_d.sdaLow = 1'b1;
            2'h3: begin
              core_d.sclLow = 1'b1;
              core_d.bitIdx = 4'h0;
              core_d.state = ssm_pkg::ST_BIT;
            end
          endcase
        end
      end
      ssm_pkg::ST_BIT: begin
        if (tick) begin
          core_d.quarter = core_q.quarter + 2'h1;
          unique case (core_q.quarter)
            2'h0: begin
              // Data moves only here, a full quarter after SCL fell.
              if (core_q.bitIdx == ssm_pkg::ACK_BIT_INDEX) begin
                core_d.sdaLow = 1'b0;
              end else if (core_q.stage == ssm_pkg::STG_READ) begin
                core_d.sdaLow = 1'b0;
              end else begin
                core_d.sdaLow = !core_q.shift[7];
              end
            end
            2'h1: core_d.sclLow = 1'b0;
            2'h2: begin
              if (core_q.bitIdx == ssm_pkg::ACK_BIT_INDEX) begin
                // A read byte is complete here, so the released nack level must not land in it.
                if (core_q.stage != ssm_pkg::STG_READ) begin
                  core_d.shift[0] = core_q.sdaSync[1];
                end
              end else if (core_q.stage == ssm_pkg::STG_READ) begin
                core_d.shift = {core_q.shift[6:0], core_q.sdaSync[1]};
              end else begin
                core_d.shift = {core_q.shift[6:0], 1'b0};
              end
            end
            2'h3: begin
              core_d.sclLow = 1'b1;
              if (core_q.bitIdx != ssm_pkg::ACK_BIT_INDEX) begin
                core_d.bitIdx = core_q.bitIdx + 4'h1;
              end else begin
                core_d.bitIdx = 4'h0;
                if (core_q.stage != ssm_pkg::STG_READ && core_q.shift[0]) begin
                  core_d.status.error = 1'b1;
                  core_d.state = ssm_pkg::ST_STOP;
                end else begin
                  unique case (core_q.stage)
                    ssm_pkg::STG_ADDR_WR: begin
                      core_d.stage = ssm_pkg::STG_SUB;
                      core_d.shift = core_q.req.subAddress;
                    end
                    ssm_pkg::STG_SUB: begin
                      if (core_q.req.readMode) begin
                        // Dummy write ends at the sub-address; no data byte.
                        core_d.stage = ssm_pkg::STG_ADDR_RD;
                        core_d.shift = {core_q.req.targetAddress, ssm_pkg::RW_READ};
                        core_d.state = ssm_pkg::ST_START;
                      end else begin
                        core_d.stage = ssm_pkg::STG_DATA;
                        core_d.shift = ssm_pkg::byteOf(core_q.req.writeData, 3'h0);
                      end
                    end
                    ssm_pkg::STG_DATA: begin
                      if ({1'b0, core_q.dataIdx} + 4'h1 == core_q.total) begin
                        core_d.state = ssm_pkg::ST_STOP;
                      end else begin
                        core_d.dataIdx = core_q.dataIdx + 3'h1;
                        core_d.shift = ssm_pkg::byteOf(core_q.req.writeData,
                                                       core_q.dataIdx + 3'h1);
                      end
                    end
                    ssm_pkg::STG_ADDR_RD: core_d.stage = ssm_pkg::STG_READ;
                    ssm_pkg::STG_READ: begin
                      // One byte only, then stop; the slave supplies it.
                      core_d.status.readData = core_q.shift;
                      core_d.state = ssm_pkg::ST_STOP;
                    end
                    default: core_d.state = ssm_pkg::ST_STOP;
                  endcase
                end
              end
            end
          endcase
        end
      end
      ssm_pkg::ST_STOP: begin
        if (tick) begin
          core_d.quarter = core_q.quarter + 2'h1;
          unique case (core_q.quarter)
            2'h0: core_d.sdaLow = 1'b1;
            2'h1: core_d.sclLow = 1'b0;
            2'h2: core_d.sdaLow = 1'b0;
            2'h3: begin
              core_d.status.ready = 1'b1;
              core_d.state = ssm_pkg::ST_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= ssm_pkg::CORE_RESET;
    end else begin
      core_q <= core_d;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sda_stable_high_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_BIT && !core_q.sclLow && !core_d.sclLow &&
     core_d.state == ssm_pkg::ST_BIT) |-> (core_d.sdaLow == core_q.sdaLow))
    else $error("SDA moved while SCL was high.");

  start_condition_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_START && $rose(core_q.sdaLow)) |->
      (!core_q.sclLow && $past(!core_q.sclLow)))
    else $error("Start did not happen with SCL high.");

  stop_condition_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_STOP && $fell(core_q.sdaLow)) |-> !core_q.sclLow)
    else $error("Stop did not happen with SCL high.");

  ready_launch_a: assert property (@(posedge clock) disable iff (!rst_n)
    (startPulse && status.ready) |=> (!status.ready && core_q.state == ssm_pkg::ST_START))
    else $error("Ready did not drop at launch.");

  ready_after_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(status.ready) |-> ($past(core_q.state) == ssm_pkg::ST_STOP &&
                            !core_q.sclLow && !core_q.sdaLow))
    else $error("Ready rose without a completed stop.");

  error_stop_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(status.error) |-> (core_q.state == ssm_pkg::ST_STOP && core_q.quarter == 2'h0))
    else $error("Error set without moving to stop.");

  read_no_ack_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_BIT && core_q.stage == ssm_pkg::STG_READ &&
     core_q.bitIdx == ssm_pkg::ACK_BIT_INDEX && core_q.quarter != 2'h0) |-> !core_q.sdaLow)
    else $error("Master acknowledged the final read byte.");

  msb_first_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_BIT && core_q.quarter == 2'h1 &&
     core_q.bitIdx != ssm_pkg::ACK_BIT_INDEX && core_q.stage != ssm_pkg::STG_READ) |->
      (core_q.sdaLow == !core_q.shift[7]))
    else $error("Transmitted bit is not the top of the shift register.");

  read_dir_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_BIT && core_q.quarter == 2'h2 && core_q.bitIdx == 4'h7 &&
     core_q.stage == ssm_pkg::STG_ADDR_RD) |-> !core_q.sdaLow)
    else $error("Read address byte lacks the read direction bit.");

  write_dir_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.state == ssm_pkg::ST_BIT && core_q.quarter == 2'h2 && core_q.bitIdx == 4'h7 &&
     core_q.stage == ssm_pkg::STG_ADDR_WR) |-> core_q.sdaLow)
    else $error("Write address byte lacks the write direction bit.");

  eeprom_rate_a: assert property (@(posedge clock) disable iff (!rst_n)
    (startPulse && status.ready && request.eepromLoad) |=> core_q.fast)
    else $error("EEPROM load did not select the fast rate.");

  write_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    (core_q.stage == ssm_pkg::STG_DATA) |-> ({1'b0, core_q.dataIdx} < core_q.total))
    else $error("Write ran past its byte count.");

endmodule : ssm_master

// ===== ssm_slave_model.sv
`timescale 1ns/1ps
// Two-wire slave with a 256-byte register file; the wires are pulled up.
module ssm_slave_model #(
  parameter logic [6:0] OWN_ADDRESS = 7'h2A
) (
  input wire logic scl,
  input wire logic sda,
  input wire logic refuseAll,
  input wire logic slowAnswer,
  input wire logic [7:0] peekAddr,
  output logic slavePull,
  output logic [7:0] peekData,
  output int startCount,
  output int stopCount,
  output logic masterNack
);
  logic [7:0] mem [256];
  logic [7:0] ptr;
  logic [7:0] shiftIn;
  logic [7:0] txByte;
  int bitNo;
  logic active;
  logic reading;
  logic isAddr;
  logic isSub;
  logic sending;

  assign peekData = mem[peekAddr];

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'h5A;
    end
    ptr = 8'h00;
    slavePull = 1'b0;
    startCount = 0;
    stopCount = 0;
    masterNack = 1'b0;
    active = 1'b0;
    reading = 1'b0;
    sending = 1'b0;
    isAddr = 1'b0;
    isSub = 1'b0;
    bitNo = 0;
  end

  always @(negedge sda) begin
    if (scl === 1'b1) begin
      startCount++;
      bitNo = -1;
      active = 1'b1;
      reading = 1'b0;
      sending = 1'b0;
      isAddr = 1'b1;
    end
  end

  always @(posedge sda) begin
    if (scl === 1'b1) begin
      stopCount++;
      active = 1'b0;
    end
  end

  always @(posedge scl) begin
    if (active && bitNo >= 0 && bitNo < 8) begin
      shiftIn = {shiftIn[6:0], sda};
    end
    if (active && bitNo == 8 && sending) begin
      masterNack = sda;
      active = !sda;
    end
  end

  // A refused address leaves the model deaf until the next start, as a real slave is.
  always @(negedge scl) begin
    if (active) begin
      bitNo = (bitNo == 8) ? 0 : bitNo + 1;
      if (reading && bitNo == 0) begin
        txByte = mem[ptr];
        ptr++;
        sending = 1'b1;
      end
      // The answer lands well inside the low phase, never while SCL is high.
      #(slowAnswer ? 550 : 50);
      if (reading && bitNo < 8) begin
        slavePull = !txByte[7 - bitNo];
      end else if (!reading && bitNo == 8) begin
        if (isAddr) begin
          slavePull = (shiftIn[7:1] == OWN_ADDRESS) && !refuseAll;
          reading = slavePull && shiftIn[0];
          active = slavePull;
          isSub = 1'b1;
          isAddr = 1'b0;
        end else if (isSub) begin
          ptr = shiftIn;
          isSub = 1'b0;
          slavePull = 1'b1;
        end else begin
          mem[ptr] = shiftIn;
          ptr++;
          slavePull = 1'b1;
        end
      end else begin
        slavePull = 1'b0;
      end
    end
  end
endmodule : ssm_slave_model

// ===== ssm_master_tb.sv
`timescale 1ns/1ps
module ssm_master_tb;
  localparam logic [6:0] SLAVE_ADDR = 7'h2A;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic startPulse = 1'b0;
  ssm_pkg::ssm_request_t request = '0;
  ssm_pkg::ssm_status_t status;
  logic sclOut;
  logic sclOe;
  logic sdaOut;
  logic sdaOe;
  logic slavePull;
  logic refuseAll = 1'b0;
  logic slowAnswer = 1'b0;
  logic [7:0] peekAddr = 8'h00;
  logic [7:0] peekData;
  int startCount;
  int stopCount;
  logic masterNack;
  int errors = 0;
  int checks_done = 0;
  integer seed = 95;
  time riseT [2];
  int riseIdx = 0;
  wire scl = sclOe ? sclOut : 1'b1;
  wire sda = ((sdaOe && !sdaOut) || slavePull) ? 1'b0 : 1'b1;

  ssm_master i_ssm_master (
    .clock(clock),
    .rst_n(rst_n),
    .startPulse(startPulse),
    .request(request),
    .status(status),
    .sclOut(sclOut),
    .sclOe(sclOe),
    .sdaIn(sda),
    .sdaOut(sdaOut),
    .sdaOe(sdaOe)
  );

  ssm_slave_model #(.OWN_ADDRESS(SLAVE_ADDR)) i_ssm_slave_model (
    .scl(scl),
    .sda(sda),
    .refuseAll(refuseAll),
    .slowAnswer(slowAnswer),
    .peekAddr(peekAddr),
    .slavePull(slavePull),
    .peekData(peekData),
    .startCount(startCount),
    .stopCount(stopCount),
    .masterNack(masterNack)
  );

  always #2.5 clock = ~clock;

  always @(posedge scl) begin
    if (riseIdx < 2) begin
      riseT[riseIdx] = $time;
    end
    riseIdx++;
  end

  function automatic int quarterOf(input ssm_pkg::ssm_request_t r);
    quarterOf = (r.highSpeed || r.eepromLoad) ? ssm_pkg::FAST_QUARTER_CYCLES
                                              : ssm_pkg::SLOW_QUARTER_CYCLES;
  endfunction : quarterOf

  task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
    checks_done++;
    if (seen !== want) begin
      errors++;
      $display("MISMATCH at %0t: %s seen %0h want %0h", $time, what, seen, want);
    end
  endtask : check

  task automatic tally_and_finish();
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish

  // A second launch is pulsed mid-transfer; the engine must ignore it.
  task automatic run_transfer(input ssm_pkg::ssm_request_t r, input logic expErr);
    int s0;
    int p0;
    int n;
    s0 = startCount;
    p0 = stopCount;
    request = r;
    startPulse = 1'b1;
    @(posedge clock);
    #1;
    startPulse = 1'b0;
    riseIdx = 0;
    @(posedge clock);
    #1;
    check(status.ready, 1'b0, "ready at launch");
    check(status.error, 1'b0, "error at launch");
    n = 0;
    while (status.ready !== 1'b1 && n < 200000) begin
      @(posedge clock);
      #1;
      n++;
      startPulse = (n == 3000);
    end
    check(status.ready, 1'b1, "ready returns");
    check(status.error, expErr, "error flag");
    check(startCount - s0, r.readMode ? 2 : 1, "starts");
    check(stopCount - p0, 1, "stops");
    check(32'(riseT[1] - riseT[0]), 4 * quarterOf(r) * 5, "scl period");
  endtask : run_transfer

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    ssm_pkg::ssm_request_t r;
    logic [63:0] wd;
    logic [7:0] sub;
    repeat (16) @(posedge clock);
    #1;
    rst_n = 1'b1;
    check({status.ready, status.error, status.readData}, 10'h200, "reset status");
    check({scl, sda}, 2'h3, "bus idle");
    r = '0;
    r.targetAddress = 7'($random(seed)) | 7'h01;
    r.byteCount = 3'h1;
    refuseAll = 1'b1;
    run_transfer(r, 1'b1);
    refuseAll = 1'b0;
    wd = {$random(seed), $random(seed)};
    // Byte three is read back later; an even value there exposes a stray bit after the byte.
    wd[24] = 1'b0;
    r = '0;
    r.highSpeed = 1'b1;
    r.targetAddress = SLAVE_ADDR;
    r.subAddress = 8'hF0;
    r.writeData = wd;
    run_transfer(r, 1'b0);
    for (int i = 0; i < 8; i++) begin
      peekAddr = 8'hF0 + 8'(i);
      #1;
      check(peekData, wd[8 * i +: 8], "written byte");
    end
    r.readMode = 1'b1;
    r.subAddress = 8'hF3;
    r.byteCount = 3'($random(seed));
    slowAnswer = 1'b1;
    run_transfer(r, 1'b0);
    slowAnswer = 1'b0;
    check(status.readData, wd[31:24], "read byte");
    check(masterNack, 1'b1, "no ack on read");
    sub = 8'($random(seed)) & 8'h7F;
    wd = 64'($random(seed));
    r = '0;
    r.eepromLoad = 1'b1;
    r.byteCount = 3'h1;
    r.targetAddress = SLAVE_ADDR;
    r.subAddress = sub;
    r.writeData = wd;
    run_transfer(r, 1'b0);
    peekAddr = sub;
    #1;
    check(peekData, wd[7:0], "single byte");
    peekAddr = sub + 8'h01;
    #1;
    check(peekData, (sub + 8'h01) ^ 8'h5A, "neighbour kept");
    tally_and_finish();
  end

  // About 100k cycles of traffic are planned; twice that cuts a hang short.
  initial begin
    #1000000;
    errors++;
    tally_and_finish();
  end
endmodule : ssm_master_tb
